// ---- smsl_chk.sv ----
`timescale 1ns/1ps
module smsl_chk #(
   parameter int P_NUM_CH = 12,
   parameter int P_READY_CYC = 20
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic [2*P_NUM_CH-1:0] o_cmp_out,
   input wire logic [P_NUM_CH-1:0] o_window,
   input wire logic o_monitors_ready
);
   logic [19:0] cyc_q;
   logic [19:0] cyc_d;
   logic [P_NUM_CH-1:0] win_c;

   // Cycles since reset release, saturating so it never wraps back into the early region
   always_comb begin
      cyc_d = (cyc_q == 20'hF_FFFF) ? cyc_q : cyc_q + 20'h0_0001;
      for (int c = 0; c < P_NUM_CH; c++) begin
         win_c[c] = o_cmp_out[2*c] & ~o_cmp_out[2*c+1];
      end
   end

   always_ff @(posedge i_clk) begin
      cyc_q <= i_rst ? 20'h0_0000 : cyc_d;
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_setup;
      i_psel && !i_penable && !o_pready;
   endsequence
   sequence s_quiet_out;
      (o_cmp_out == '0) ##1 (o_cmp_out == '0);
   endsequence

   // One cycle of slack on each side of the calibration time
   a_ready_early: assert property (cyc_q < P_READY_CYC - 1 |-> !o_monitors_ready)
      else $error("monitors ready came too early");
   a_ready_bound: assert property (cyc_q >= P_READY_CYC + 1 |-> o_monitors_ready)
      else $error("monitors ready late");
   a_ready_stays: assert property (o_monitors_ready |=> o_monitors_ready)
      else $error("monitors ready dropped");
   a_cmp_gated: assert property (!o_monitors_ready |-> o_cmp_out == '0)
      else $error("comparator output before ready");
   a_ready_quiet: assert property ($rose(o_monitors_ready) |-> s_quiet_out)
      else $error("filters not initialised at ready");
   a_window_tracks: assert property (o_window == $past(win_c))
      else $error("window flag wrong");
   a_pready_answer: assert property (s_setup |=> o_pready)
      else $error("no answer after setup");
   a_pready_pulse: assert property (o_pready |=> !o_pready)
      else $error("pready longer than one cycle");
   a_pready_cause: assert property ($rose(o_pready) |-> $past(i_psel && !i_penable))
      else $error("pready without setup");
   a_err_rdata: assert property (o_pslverr |-> o_pready && o_prdata == 32'h0000_0000)
      else $error("error response malformed");
endmodule

bind smsl_top smsl_chk #(.P_NUM_CH(P_NUM_CH), .P_READY_CYC(P_READY_CYC)) u_chk (
   .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .o_cmp_out(o_cmp_out), .o_window(o_window),
   .o_monitors_ready(o_monitors_ready));

// ---- smsl_pkg.sv ----
package smsl_pkg;
   // Channel structure
   localparam int NUM_CH = 12;
   localparam int MV_W = 13;
   localparam int SET_W = 9;
   localparam int NUM_SETTINGS = 368;
   localparam int TRIP_MIN_MV = 664;
   localparam int TRIP_MAX_MV = 5734;
   localparam int NEAR_GND_MV = 75;
   localparam int HYST_DIV = 100;
   localparam int CNT_W = 20;
   localparam int CH_IDX_W = 4;

   // Timing, printed figures and derived cycle counts
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_READY_NS = 2_500_000;
   localparam int T_FILT_OFF_NS = 16_000;
   localparam int T_FILT_ON_NS = 64_000;
   localparam int READY_CYC = T_READY_NS / CLK_PERIOD_NS;
   localparam int FILT_OFF_CYC = T_FILT_OFF_NS / CLK_PERIOD_NS;
   localparam int FILT_ON_CYC = T_FILT_ON_NS / CLK_PERIOD_NS;
   localparam int CONV_CYC = 1000;

   // Register byte offsets
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_ADC_CTRL = 12'h00C;
   localparam logic [ADDR_W-1:0] OFS_ADC_RESULT = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_CMP_OUT = 12'h014;
   localparam logic [ADDR_W-1:0] OFS_WINDOW = 12'h018;
   localparam logic [ADDR_W-1:0] OFS_CMP_CFG = 12'h040;

   // Field positions
   localparam int CFG_W = 11;
   localparam int CFG_NEAR_BIT = 9;
   localparam int CFG_FILT_BIT = 10;
   localparam int ADC_START_BIT = 8;
   localparam int ST_READY_BIT = 0;
   localparam int ST_BUSY_BIT = 1;
   localparam int ST_DONE_BIT = 2;
   localparam int IRQ_W = 2;
   localparam int IRQ_READY_BIT = 0;
   localparam int IRQ_DONE_BIT = 1;

   // Reset values
   localparam logic [CFG_W-1:0] CFG_RST = 11'h000;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

   typedef enum logic [1:0] {
      SMSL_CAL = 2'b01,
      SMSL_RUN = 2'b10
   } smsl_init_e;

   typedef enum logic [1:0] {
      SMSL_ADC_IDLE = 2'b01,
      SMSL_ADC_CONV = 2'b10
   } smsl_adc_e;
endpackage

// ---- smsl_rail_model.sv ----
`timescale 1ns/1ps
module smsl_rail_model #(
   parameter int P_NUM_CH = 12
) (
   input wire logic [2*P_NUM_CH-1:0] i_cmp_out,
   input wire logic i_monitors_ready,
   output logic [P_NUM_CH*smsl_pkg::MV_W-1:0] o_pos,
   output logic [P_NUM_CH*smsl_pkg::MV_W-1:0] o_gnd,
   output logic [2*P_NUM_CH-1:0] o_used
);
   import smsl_pkg::*;
   logic [P_NUM_CH*MV_W-1:0] pos_q = '0;
   logic [P_NUM_CH*MV_W-1:0] gnd_q = '0;

   // Rail and remote ground of one supply, both sensed differentially
   task automatic set_rail(input int c, input int p, input int g);
      pos_q[c*MV_W +: MV_W] <= MV_W'(p);
      gnd_q[c*MV_W +: MV_W] <= MV_W'(g);
   endtask

   assign o_pos = pos_q;
   assign o_gnd = gnd_q;
   // Sequencing logic sees nothing until calibration is over
   assign o_used = i_monitors_ready ? i_cmp_out : '0;
endmodule

// ---- smsl_tb_top.sv ----
`timescale 1ns/1ps
module smsl_tb_top;
   import smsl_pkg::*;
   localparam int RDY = 20;
   localparam int FOFF = 3;
   localparam int FON = 8;
   localparam int CONV = 5;
   logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, irq, ready, errv;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [NUM_CH*MV_W-1:0] pos, gnd;
   logic [2*NUM_CH-1:0] cmp, used;
   logic [NUM_CH-1:0] win;
   int mismatches, n_tests, cycles, n;

   smsl_top #(.P_READY_CYC(RDY), .P_FILT_OFF_CYC(FOFF), .P_FILT_ON_CYC(FON), .P_CONV_CYC(CONV)) uut (
      .i_clk(clk), .i_rst(rst), .i_ce(ce), .i_monitor_positive_sense(pos), .i_monitor_ground_sense(gnd),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_cmp_out(cmp), .o_window(win),
      .o_monitors_ready(ready), .o_irq(irq));
   smsl_rail_model u_rail (.i_cmp_out(cmp), .i_monitors_ready(ready), .o_pos(pos), .o_gnd(gnd), .o_used(used));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         final_report();
      end
   end

   task automatic final_report();
      $display("mismatches %0d n_tests %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Setup, access, then hold until pready is sampled high
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      // Waits for the answer however long; only the hang guard ends a stuck wait
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready wait", k, 1);
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string what);
      xfer(1'b0, a, 32'h0000_0000);
      chk(what, rdv, exp);
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   // Filter off settles in a few cycles; ten leaves slack
   task automatic step(input int p, input int g, input logic exp, input string what);
      u_rail.set_rail(0, p, g);
      cyc(10);
      chk(what, used[0], exp);
   endtask

   initial begin
      rst = 1'b1;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = 32'h0000_0000;
      mismatches = 0;
      n_tests = 0;
      cycles = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      cyc(RDY - 4);
      chk("ready early", ready, 0);
      chk("cmp gated", used, 0);
      cyc(6);
      chk("ready", ready, 1);
      rd(OFS_STATUS, 32'h0000_0001, "status");
      rd(OFS_IRQ_STAT, 32'h0000_0001, "ready event");
      rd(OFS_IRQ_MASK, 32'h0000_0000, "mask reset");
      chk("irq masked", irq, 0);
      xfer(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
      cyc(2);
      chk("irq on", irq, 1);
      xfer(1'b1, OFS_IRQ_STAT, 32'h0000_0001);
      cyc(2);
      chk("irq off", irq, 0);
      rd(OFS_IRQ_STAT, 32'h0000_0000, "stat cleared");
      xfer(1'b1, OFS_STATUS, 32'h0000_0000);
      rd(OFS_STATUS, 32'h0000_0001, "status read only");
      xfer(1'b0, 12'h020, 32'h0000_0000);
      chk("unmapped err", errv, 1);
      for (int c = 0; c < 2 * NUM_CH; c++) rd(ADDR_W'(OFS_CMP_CFG + 4 * c), 32'h0000_0000, "cfg reset");
      // Each channel alone; both comparators share the lowest threshold
      for (int c = 0; c < NUM_CH; c++) begin
         u_rail.set_rail(c, 1000, 0);
         cyc(10);
         chk("channel cmp", used, 32'(24'h3 << (2 * c)));
         chk("window both high", win, 0);
         u_rail.set_rail(c, 0, 0);
         cyc(10);
      end
      xfer(1'b1, ADDR_W'(OFS_CMP_CFG + 4), 32'h0000_016F);
      step(1000, 0, 1, "in window");
      chk("window", win[0], 1);
      chk("second cmp top", used[1], 0);
      step(660, 0, 1, "hold above lower");
      step(650, 0, 0, "fall below lower");
      step(660, 0, 0, "no rise below upper");
      step(1600, 900, 1, "diff rise");
      step(1600, 1000, 0, "diff fall");
      xfer(1'b1, OFS_CMP_CFG, 32'h0000_0200);
      step(100, 0, 1, "near ground high");
      step(50, 0, 0, "near ground low");
      // Glitch filter on: same stimulus, must still be low when the short path would have switched
      xfer(1'b1, OFS_CMP_CFG, 32'h0000_0400);
      u_rail.set_rail(0, 1000, 0);
      cyc(8);
      chk("filter slow", used[0], 0);
      cyc(8);
      chk("filter on", used[0], 1);
      // Conversion, polled through the done flag as a fast host would
      u_rail.set_rail(0, 1234, 34);
      cyc(4);
      xfer(1'b1, OFS_ADC_CTRL, 32'h0000_0100);
      n = 0;
      do begin
         xfer(1'b0, OFS_STATUS, 32'h0000_0000);
         n++;
      end while (rdv[ST_DONE_BIT] !== 1'b1 && n < 20);
      chk("done", rdv[ST_DONE_BIT], 1);
      rd(OFS_ADC_RESULT, 32'h0000_04B0, "result");
      rd(OFS_IRQ_STAT, 32'h0000_0002, "done event");
      xfer(1'b1, OFS_ADC_CTRL, 32'h0000_010C);
      rd(OFS_STATUS, 32'h0000_0005, "bad channel ignored");
      // Slow host: waits the conversion time instead of trusting the done flag
      u_rail.set_rail(1, 2000, 500);
      xfer(1'b1, OFS_ADC_CTRL, 32'h0000_0101);
      rd(OFS_STATUS, 32'h0000_0003, "busy and done cleared");
      cyc(CONV);
      rd(OFS_ADC_RESULT, 32'h0000_05DC, "slow host result");
      rd(OFS_ADC_CTRL, 32'h0000_0001, "last channel");
      // Clock enable low freezes the comparators even though the rail moved
      ce <= 1'b0;
      u_rail.set_rail(2, 1000, 0);
      cyc(10);
      chk("ce freeze", used[5:4], 2'b00);
      ce <= 1'b1;
      cyc(10);
      chk("ce run", used[5:4], 2'b11);
      final_report();
   end
endmodule

// ---- smsl_top.sv ----
`timescale 1ns/1ps
module smsl_top #(
   parameter int P_NUM_CH = smsl_pkg::NUM_CH,
   parameter int P_READY_CYC = smsl_pkg::READY_CYC,
   parameter int P_FILT_OFF_CYC = smsl_pkg::FILT_OFF_CYC,
   parameter int P_FILT_ON_CYC = smsl_pkg::FILT_ON_CYC,
   parameter int P_CONV_CYC = smsl_pkg::CONV_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic [P_NUM_CH*smsl_pkg::MV_W-1:0] i_monitor_positive_sense,
   input wire logic [P_NUM_CH*smsl_pkg::MV_W-1:0] i_monitor_ground_sense,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [smsl_pkg::ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   output logic [2*P_NUM_CH-1:0] o_cmp_out,
   output logic [P_NUM_CH-1:0] o_window,
   output logic o_monitors_ready,
   output logic o_irq
);
   import smsl_pkg::*;

   localparam int N_CMP = 2 * P_NUM_CH;

   // Refuse sizes the register layout or counters cannot carry, bar a P_FILT_OFF_CYC too large for the filter counter
   if (P_NUM_CH < 1 || P_NUM_CH > 16) begin : g_chk_ch
      $error("P_NUM_CH must be 1..16");
   end
   if (P_READY_CYC < 1 || P_READY_CYC >= 2**CNT_W || P_CONV_CYC < 1 || P_CONV_CYC >= 2**CNT_W) begin : g_chk_t
      $error("ready or conversion count out of range");
   end
   if (P_FILT_OFF_CYC < 1 || P_FILT_ON_CYC < 1 || P_FILT_ON_CYC >= 2**CNT_W) begin : g_chk_f
      $error("filter counts out of range");
   end

   // Upper trip point in mV for one configuration word
   function automatic logic [MV_W-1:0] trip_upper(input logic [CFG_W-1:0] cfg);
      int idx;
      int mv;
      idx = int'(cfg[SET_W-1:0]);
      if (idx > NUM_SETTINGS - 1) begin
         idx = NUM_SETTINGS - 1;
      end
      mv = TRIP_MIN_MV + (idx * (TRIP_MAX_MV - TRIP_MIN_MV)) / (NUM_SETTINGS - 1);
      if (cfg[CFG_NEAR_BIT]) begin
         mv = NEAR_GND_MV;
      end
      return mv[MV_W-1:0];
   endfunction

   // Lower trip point sits about one percent under the upper one
   function automatic logic [MV_W-1:0] trip_lower(input logic [CFG_W-1:0] cfg);
      logic [MV_W-1:0] up;
      up = trip_upper(cfg);
      return up - MV_W'(up / HYST_DIV);
   endfunction

   // Config register decode, shared by read and write paths
   function automatic logic is_cfg(input logic [ADDR_W-1:0] a);
      return (a >= OFS_CMP_CFG) && (int'(a) < int'(OFS_CMP_CFG) + 4 * N_CMP) && (a[1:0] == 2'b00);
   endfunction

   function automatic int cfg_index(input logic [ADDR_W-1:0] a);
      return (int'(a) - int'(OFS_CMP_CFG)) / 4;
   endfunction

   // State
   smsl_init_e init_q, init_d;
   logic [CNT_W-1:0] cal_cnt_q, cal_cnt_d;
   logic ready_q, ready_d;
   logic ready_evt;
   smsl_adc_e adc_q, adc_d;
   logic [CNT_W-1:0] conv_cnt_q, conv_cnt_d;
   logic [CH_IDX_W-1:0] adc_ch_q, adc_ch_d;
   logic [MV_W-1:0] adc_res_q, adc_res_d;
   logic done_q, done_d;
   logic done_evt;
   logic [MV_W-1:0] diff_q [P_NUM_CH];
   logic [MV_W-1:0] diff_d [P_NUM_CH];
   logic [CFG_W-1:0] cfg_q [N_CMP];
   logic [CFG_W-1:0] cfg_d [N_CMP];
   logic [N_CMP-1:0] raw_q, raw_d;
   logic [N_CMP-1:0] filt_q, filt_d;
   logic [CNT_W-1:0] fcnt_q [N_CMP];
   logic [CNT_W-1:0] fcnt_d [N_CMP];
   logic [P_NUM_CH-1:0] win_q, win_d;
   logic [IRQ_W-1:0] irq_stat_q, irq_stat_d;
   logic [IRQ_W-1:0] irq_mask_q, irq_mask_d;
   logic irq_q, irq_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic [31:0] prdata_q, prdata_d;
   logic setup;
   logic wr_en;

   // Bus phase decode; writes land on the completing access edge
   assign setup = i_psel && !i_penable && !pready_q;
   assign wr_en = i_psel && i_penable && pready_q && i_pwrite;

   // Power-up calibration sequence; a counter stands in for the analog trim time
   always_comb begin
      init_d = init_q;
      cal_cnt_d = cal_cnt_q;
      ready_d = ready_q;
      ready_evt = 1'b0;
      unique case (init_q)
         SMSL_CAL: begin
            if (int'(cal_cnt_q) >= P_READY_CYC - 1) begin
               init_d = SMSL_RUN;
               ready_d = 1'b1;
               ready_evt = 1'b1;
            end else begin
               cal_cnt_d = cal_cnt_q + CNT_W'(1);
            end
         end
         SMSL_RUN: begin
            ready_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         init_q <= SMSL_CAL;
         cal_cnt_q <= '0;
         ready_q <= 1'b0;
      end else if (i_ce) begin
         init_q <= init_d;
         cal_cnt_q <= cal_cnt_d;
         ready_q <= ready_d;
      end
   end

   // Sensing, hysteresis comparators, glitch filters and window control
   always_comb begin
      logic [MV_W-1:0] pos;
      logic [MV_W-1:0] gnd;
      int dly;
      pos = '0;
      gnd = '0;
      dly = 0;
      for (int c = 0; c < P_NUM_CH; c++) begin
         pos = i_monitor_positive_sense[c*MV_W +: MV_W];
         gnd = i_monitor_ground_sense[c*MV_W +: MV_W];
         diff_d[c] = (pos > gnd) ? pos - gnd : '0;
      end
      for (int i = 0; i < N_CMP; i++) begin
         // Rise only above the upper point, fall only below the lower one
         raw_d[i] = raw_q[i];
         if (!raw_q[i] && diff_q[i/2] > trip_upper(cfg_q[i])) begin
            raw_d[i] = 1'b1;
         end else if (raw_q[i] && diff_q[i/2] < trip_lower(cfg_q[i])) begin
            raw_d[i] = 1'b0;
         end
         dly = cfg_q[i][CFG_FILT_BIT] ? P_FILT_ON_CYC : P_FILT_OFF_CYC;
         filt_d[i] = filt_q[i];
         fcnt_d[i] = '0;
         if (raw_q[i] != filt_q[i]) begin
            if (int'(fcnt_q[i]) >= dly - 1) begin
               filt_d[i] = raw_q[i];
            end else begin
               fcnt_d[i] = fcnt_q[i] + CNT_W'(1);
            end
         end
         // Filters and comparators are held cleared while calibrating
         if (!ready_q) begin
            raw_d[i] = 1'b0;
            filt_d[i] = 1'b0;
            fcnt_d[i] = '0;
         end
      end
      for (int c = 0; c < P_NUM_CH; c++) begin
         win_d[c] = filt_q[2*c] && !filt_q[2*c+1];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         raw_q <= '0;
         filt_q <= '0;
         win_q <= '0;
         diff_q <= '{default: '0};
         fcnt_q <= '{default: '0};
      end else if (i_ce) begin
         raw_q <= raw_d;
         filt_q <= filt_d;
         win_q <= win_d;
         diff_q <= diff_d;
         fcnt_q <= fcnt_d;
      end
   end

   // Converter sequence; done is always raised, whatever the bus rate
   always_comb begin
      adc_d = adc_q;
      conv_cnt_d = conv_cnt_q;
      adc_ch_d = adc_ch_q;
      adc_res_d = adc_res_q;
      done_d = done_q;
      done_evt = 1'b0;
      unique case (adc_q)
         SMSL_ADC_IDLE: begin
            // Starts naming a missing channel are dropped
            if (wr_en && i_paddr == OFS_ADC_CTRL && i_pwdata[ADC_START_BIT]
                && int'(i_pwdata[CH_IDX_W-1:0]) < P_NUM_CH) begin
               adc_d = SMSL_ADC_CONV;
               adc_ch_d = i_pwdata[CH_IDX_W-1:0];
               conv_cnt_d = '0;
               done_d = 1'b0;
            end
         end
         SMSL_ADC_CONV: begin
            if (int'(conv_cnt_q) >= P_CONV_CYC - 1) begin
               adc_d = SMSL_ADC_IDLE;
               adc_res_d = diff_q[adc_ch_q];
               done_d = 1'b1;
               done_evt = 1'b1;
            end else begin
               conv_cnt_d = conv_cnt_q + CNT_W'(1);
            end
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         adc_q <= SMSL_ADC_IDLE;
         conv_cnt_q <= '0;
         adc_ch_q <= '0;
         adc_res_q <= '0;
         done_q <= 1'b0;
      end else if (i_ce) begin
         adc_q <= adc_d;
         conv_cnt_q <= conv_cnt_d;
         adc_ch_q <= adc_ch_d;
         adc_res_q <= adc_res_d;
         done_q <= done_d;
      end
   end

   // Register file, interrupt logic and APB answer
   always_comb begin
      logic hit;
      hit = 1'b1;
      cfg_d = cfg_q;
      irq_mask_d = irq_mask_q;
      irq_stat_d = irq_stat_q;
      if (wr_en && i_paddr == OFS_IRQ_MASK) begin
         irq_mask_d = i_pwdata[IRQ_W-1:0];
      end
      if (wr_en && i_paddr == OFS_IRQ_STAT) begin
         irq_stat_d = irq_stat_q & ~i_pwdata[IRQ_W-1:0];
      end
      // A new event outranks a clear in the same cycle
      irq_stat_d[IRQ_READY_BIT] = irq_stat_d[IRQ_READY_BIT] | ready_evt;
      irq_stat_d[IRQ_DONE_BIT] = irq_stat_d[IRQ_DONE_BIT] | done_evt;
      if (wr_en && is_cfg(i_paddr)) begin
         cfg_d[cfg_index(i_paddr)] = i_pwdata[CFG_W-1:0];
      end
      irq_d = |(irq_stat_q & irq_mask_q);
      pready_d = setup;
      pslverr_d = 1'b0;
      prdata_d = '0;
      if (setup) begin
         unique case (i_paddr)
            OFS_STATUS: begin
               prdata_d[ST_READY_BIT] = ready_q;
               prdata_d[ST_BUSY_BIT] = (adc_q == SMSL_ADC_CONV);
               prdata_d[ST_DONE_BIT] = done_q;
            end
            OFS_IRQ_STAT: prdata_d[IRQ_W-1:0] = irq_stat_q;
            OFS_IRQ_MASK: prdata_d[IRQ_W-1:0] = irq_mask_q;
            OFS_ADC_CTRL: prdata_d[CH_IDX_W-1:0] = adc_ch_q;
            OFS_ADC_RESULT: prdata_d[MV_W-1:0] = adc_res_q;
            OFS_CMP_OUT: prdata_d[N_CMP-1:0] = filt_q;
            OFS_WINDOW: prdata_d[P_NUM_CH-1:0] = win_q;
            default: begin
               hit = is_cfg(i_paddr);
               if (hit) begin
                  prdata_d[CFG_W-1:0] = cfg_q[cfg_index(i_paddr)];
               end
            end
         endcase
         pslverr_d = !hit;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cfg_q <= '{default: CFG_RST};
         irq_mask_q <= IRQ_MASK_RST;
         irq_stat_q <= '0;
         irq_q <= 1'b0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else if (i_ce) begin
         cfg_q <= cfg_d;
         irq_mask_q <= irq_mask_d;
         irq_stat_q <= irq_stat_d;
         irq_q <= irq_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
      end
   end

   // Outputs straight from flops; comparator outputs stay low until ready
   assign o_prdata = prdata_q;
   assign o_pready = pready_q;
   assign o_pslverr = pslverr_q;
   assign o_cmp_out = filt_q;
   assign o_window = win_q;
   assign o_monitors_ready = ready_q;
   assign o_irq = irq_q;
endmodule
